/* low_power_mode_and_clock_supervisor.sv */
// power mode sequencer, clock fallback, boot select and register file
//
// Function
// - sleep stops only the core clock; peripheral and converter run
// - sleep wakes on interrupt after wfi, on event after wfe
// - deep bit without power-down bit plus wfi/wfe enters stop
// - stop turns both fast oscillators off and gates peripherals
// - stop and deep stop wake on any interrupt line or watchdog
// - power-down, regulator and deep bits plus wfi/wfe: deep stop
// - deep stop halts all core clocks, pll and both oscillators
// - power-down and deep bits without regulator bit: standby
// - standby turns off regulator, core supply, pll and oscillators
// - standby exits only on wake pin rise, reset pin, watchdog or supply reset
// - standby exit is a full chip reset
// - after any reset the system clock is the internal oscillator
// - external clock failure blocks it, stops pll, falls back
// - fallback raises an interrupt only when monitoring is enabled
// - separate bus prescalers, none faster than the system clock
// - voltage monitor idle until enabled, then flags each crossing
// - reset held while supply below threshold, no external part
// - boot pin and option bit sampled at startup pick boot region
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.svh"
module low_power_mode_and_clock_supervisor (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core
  input wire logic wait_for_interrupt_instr_i,
  input wire logic wait_for_event_instr_i,
  input wire logic irq_any_i,
  input wire logic wake_event_i,
  // wake and reset sources
  input wire logic [15:0] external_interrupt_lines_i,
  input wire logic wake_pin_i,
  input wire logic external_reset_pin_n_i,
  input wire logic independent_watchdog_reset_i,
  input wire logic supply_threshold_reset_i,
  input wire logic supply_voltage_monitor_i,
  input wire logic ext_clock_valid_i,
  // boot straps
  input wire logic boot_select_pin_i,
  input wire logic boot_option_bit_i,
  // clock and power control
  output lpm_pkg::clock_gates_type gates_o,
  output logic sys_clk_ext_o,
  output logic [2:0] bus_clk_en_o,
  output logic chip_reset_o,
  output logic [1:0] boot_region_o,
  output logic irq_o
);
  import lpm_pkg::*;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic sys_rst;
  logic rst_hold_reg;
  logic reset_req;
  logic [`CTRL_W-1:0] ctrl_reg;
  logic [`PRESC_W-1:0] presc_reg;
  logic [`STAT_W-1:0] stat_reg;
  logic [`STAT_W-1:0] stat_next;
  logic [`STAT_W-1:0] mask_reg;
  logic [`STAT_W-1:0] mask_next;
  power_state_type state_reg;
  power_state_type state_next;
  logic entry_wfe_reg;
  logic sel_ext_reg;
  logic sel_ext_next;
  logic hse_blocked_reg;
  logic hse_blocked_next;
  logic wake_prev_reg;
  logic vmon_prev_reg;
  logic boot_pending_reg;
  clock_gates_type gates_next;

  // reset hold comes from the supply, reset pin, watchdog, standby exit
  assign sys_rst = rst_i | rst_hold_reg;
  assign chip_reset_o = rst_hold_reg;

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready & pwrite;
  wire hit_ctrl = paddr == `CTRL_OFF;
  wire hit_presc = paddr == `PRESC_OFF;
  wire hit_stat = paddr == `STAT_OFF;
  wire hit_mask = paddr == `MASK_OFF;
  wire hit_state = paddr == `STATE_OFF;
  wire mapped = hit_ctrl | hit_presc | hit_stat | hit_mask | hit_state;
  wire [31:0] state_word = {24'h000000, supply_voltage_monitor_i,
    boot_region_o, hse_blocked_reg, sel_ext_reg, state_reg};
  wire [31:0] rdata_mux =
    hit_ctrl ? {26'h0000000, ctrl_reg} :
    hit_presc ? {20'h00000, presc_reg} :
    hit_stat ? {29'h00000000, stat_reg} :
    hit_mask ? {29'h00000000, mask_reg} :
    hit_state ? state_word : 32'h00000000;

  // ---------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------
  wire lprs = ctrl_reg[`CTRL_LPRS];
  wire power_down_deep_select = ctrl_reg[`CTRL_POWER_DOWN_DEEP_SELECT];
  wire deep = ctrl_reg[`CTRL_DEEP];
  wire cfm_en = ctrl_reg[`CTRL_CFM_EN];
  wire vmon_en = ctrl_reg[`CTRL_VMON_EN];
  wire ext_req = ctrl_reg[`CTRL_EXT_REQ];

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  wire lp_instr = wait_for_interrupt_instr_i | wait_for_event_instr_i;
  wire in_stop = (state_reg == STOP) | (state_reg == DSTOP);
  wire vmon_evt = vmon_en & (supply_voltage_monitor_i ^ vmon_prev_reg);
  wire clk_fail = sel_ext_reg & ~ext_clock_valid_i;
  wire stop_wake = (|external_interrupt_lines_i) | vmon_evt;
  wire wake_rise = wake_pin_i & ~wake_prev_reg;
  wire sleep_wake = entry_wfe_reg ? wake_event_i : irq_any_i;

  // standby exit only through the reset path
  assign reset_req = supply_threshold_reset_i
    | ~external_reset_pin_n_i | independent_watchdog_reset_i
    | ((state_reg == STANDBY) & wake_rise);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_hold_reg <= 1'b1;
    end else begin
      rst_hold_reg <= reset_req;
    end
  end

  // ---------------------------------------------------------------
  // power mode sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RUN: begin
        if (lp_instr) begin
          if (!deep) begin
            state_next = SLEEP;
          end else if (power_down_deep_select && !lprs) begin
            state_next = STANDBY;
          end else if (power_down_deep_select) begin
            state_next = DSTOP;
          end else begin
            state_next = STOP;
          end
        end
      end
      SLEEP: state_next = sleep_wake ? RUN : state_reg;
      STOP, DSTOP: state_next = stop_wake ? RUN : state_reg;
      STANDBY: state_next = STANDBY;
      default: state_next = RUN;
    endcase
  end
  wire next_active = (state_next == RUN) | (state_next == SLEEP);
  wire next_stop = (state_next == STOP) | (state_next == DSTOP);

  // ---------------------------------------------------------------
  // clock source selection and gating
  // ---------------------------------------------------------------
  assign hse_blocked_next = clk_fail | (hse_blocked_reg & ext_req);
  assign sel_ext_next = ~clk_fail & next_active & ext_req
    & ~hse_blocked_reg & ext_clock_valid_i;

  always_comb begin
    gates_next.core = state_next == RUN;
    gates_next.periph = next_active;
    gates_next.adc = next_active;
    gates_next.internal_fast_oscillator = next_active;
    gates_next.external_crystal_oscillator = next_active & ext_req
      & ~hse_blocked_next;
    gates_next.pll = next_active & ext_req & ~hse_blocked_next;
    gates_next.regulator = state_next != STANDBY;
    gates_next.low_power_reg = next_stop & lprs;
    gates_next.core_domain = state_next != STANDBY;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      state_reg <= RUN;
      entry_wfe_reg <= 1'b0;
      sel_ext_reg <= 1'b0;
      hse_blocked_reg <= 1'b0;
      gates_o <= `GATES_RST;
    end else begin
      state_reg <= state_next;
      if (state_reg == RUN && lp_instr) begin
        entry_wfe_reg <= ~wait_for_interrupt_instr_i;
      end
      sel_ext_reg <= sel_ext_next;
      hse_blocked_reg <= hse_blocked_next;
      gates_o <= gates_next;
    end
  end
  assign sys_clk_ext_o = sel_ext_reg;
  // ---------------------------------------------------------------
  // boot region capture
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      boot_pending_reg <= 1'b1;
      boot_region_o <= `BOOT_FLASH;
    end else if (boot_pending_reg) begin
      boot_pending_reg <= 1'b0;
      boot_region_o <= !boot_select_pin_i ? `BOOT_FLASH :
        boot_option_bit_i ? `BOOT_SRAM : `BOOT_SYSMEM;
    end
  end

  // ---------------------------------------------------------------
  // bus prescalers
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : gen_presc
      clk_prescaler u_presc (
        .clk_i(clk_i),
        .rst_i(sys_rst),
        .run_i(gates_o.periph),
        .div_i(presc_reg[4*g +: 4]),
        .tick_o(bus_clk_en_o[g])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // registers, status and interrupt
  // ---------------------------------------------------------------
  wire [`STAT_W-1:0] stat_set;
  assign stat_set[`STAT_CLKFAIL] = clk_fail & cfm_en;
  assign stat_set[`STAT_VMON] = vmon_evt;
  assign stat_set[`STAT_WAKE] = in_stop & stop_wake;
  wire [`STAT_W-1:0] stat_clr =
    (wr_en & hit_stat) ? pwdata[`STAT_W-1:0] : `STAT_RST;
  // set wins over a same-cycle clear
  assign stat_next = (stat_reg & ~stat_clr) | stat_set;
  assign mask_next = (wr_en & hit_mask) ? pwdata[`STAT_W-1:0] : mask_reg;

  always_ff @(posedge clk_i) begin
    if (sys_rst) begin
      ctrl_reg <= `CTRL_RST;
      presc_reg <= `PRESC_RST;
      stat_reg <= `STAT_RST;
      mask_reg <= `MASK_RST;
      irq_o <= 1'b0;
    end else begin
      if (wr_en && hit_ctrl) begin
        ctrl_reg <= pwdata[`CTRL_W-1:0];
      end
      if (wr_en && hit_presc) begin
        presc_reg <= pwdata[`PRESC_W-1:0];
      end
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_o <= |(stat_next & mask_next);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      wake_prev_reg <= 1'b0;
      vmon_prev_reg <= 1'b0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= (setup & ~pwrite) ? rdata_mux : 32'h00000000;
      wake_prev_reg <= wake_pin_i;
      vmon_prev_reg <= supply_voltage_monitor_i;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_sleep_gates;
    @(posedge clk_i) disable iff (sys_rst)
    state_reg == SLEEP |-> !gates_o.core && gates_o.periph && gates_o.adc;
  endproperty
  a_sleep_gates: assert property (p_sleep_gates)
    else $error("sleep clock gating wrong");
  property p_sleep_wake;
    @(posedge clk_i) disable iff (sys_rst)
    state_reg == SLEEP && !entry_wfe_reg && irq_any_i |=> state_reg == RUN;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("sleep did not wake on interrupt");
  property p_stop_entry;
    @(posedge clk_i) disable iff (sys_rst)
    state_reg == RUN && lp_instr && deep && lprs && !power_down_deep_select
      |=> state_reg == STOP;
  endproperty
  a_stop_entry: assert property (p_stop_entry)
    else $error("stop not entered");
  property p_stop_gates;
    @(posedge clk_i) disable iff (sys_rst)
    in_stop |-> !gates_o.internal_fast_oscillator
      && !gates_o.external_crystal_oscillator && !gates_o.periph;
  endproperty
  a_stop_gates: assert property (p_stop_gates)
    else $error("stop left a clock running");
  property p_stop_wake;
    @(posedge clk_i) disable iff (sys_rst)
    in_stop && |external_interrupt_lines_i |=> state_reg == RUN;
  endproperty
  a_stop_wake: assert property (p_stop_wake)
    else $error("stop did not wake on line");
  property p_dstop_clocks;
    @(posedge clk_i) disable iff (sys_rst)
    state_reg == DSTOP |-> !gates_o.pll && !gates_o.core && !gates_o.adc;
  endproperty
  a_dstop_clocks: assert property (p_dstop_clocks)
    else $error("deep stop clock still on");
  property p_standby_power;
    @(posedge clk_i) disable iff (sys_rst)
    state_reg == STANDBY |-> !gates_o.regulator && !gates_o.core_domain;
  endproperty
  a_standby_power: assert property (p_standby_power)
    else $error("standby supply still on");
  property p_standby_exit;
    @(posedge clk_i) disable iff (rst_i)
    state_reg == STANDBY && wake_rise |=> chip_reset_o ##1 state_reg == RUN;
  endproperty
  a_standby_exit: assert property (p_standby_exit)
    else $error("standby wake not a reset");
  property p_clk_fallback;
    @(posedge clk_i) disable iff (sys_rst)
    clk_fail |=> !sel_ext_reg && !gates_o.pll && hse_blocked_reg;
  endproperty
  a_clk_fallback: assert property (p_clk_fallback)
    else $error("no fallback on clock failure");
  property p_clk_irq;
    @(posedge clk_i) disable iff (sys_rst)
    clk_fail |=> stat_reg[`STAT_CLKFAIL] == $past(cfm_en)
      || $past(stat_reg[`STAT_CLKFAIL]);
  endproperty
  a_clk_irq: assert property (p_clk_irq)
    else $error("clock failure flag wrong");
  property p_plain_sleep;
    @(posedge clk_i) disable iff (sys_rst)
    state_reg == RUN && lp_instr && !deep |=> state_reg == SLEEP;
  endproperty
  a_plain_sleep: assert property (p_plain_sleep)
    else $error("plain sleep not entered");
endmodule : low_power_mode_and_clock_supervisor
`default_nettype wire

/* lpm_map.svh */
// register offsets, field positions, reset values and codes
`ifndef LPM_MAP_SVH
`define LPM_MAP_SVH
`define CTRL_OFF 12'h000
`define PRESC_OFF 12'h004
`define STAT_OFF 12'h008
`define MASK_OFF 12'h00C
`define STATE_OFF 12'h010
`define CTRL_LPRS 0
`define CTRL_POWER_DOWN_DEEP_SELECT 1
`define CTRL_DEEP 2
`define CTRL_CFM_EN 3
`define CTRL_VMON_EN 4
`define CTRL_EXT_REQ 5
`define CTRL_W 6
`define CTRL_RST 6'h00
`define PRESC_W 12
`define PRESC_RST 12'h000
`define STAT_CLKFAIL 0
`define STAT_VMON 1
`define STAT_WAKE 2
`define STAT_W 3
`define STAT_RST 3'h0
`define MASK_RST 3'h0
`define GATES_RST 9'h1E5
`define BOOT_FLASH 2'h0
`define BOOT_SYSMEM 2'h1
`define BOOT_SRAM 2'h2
`endif

/* lpm_pkg.sv */
// types shared by the power mode and clock supervisor
package lpm_pkg;
  typedef enum logic [2:0] {
    RUN = 3'h0,
    SLEEP = 3'h1,
    STOP = 3'h3,
    DSTOP = 3'h2,
    STANDBY = 3'h6
  } power_state_type;

  typedef struct packed {
    logic core;
    logic periph;
    logic adc;
    logic internal_fast_oscillator;
    logic external_crystal_oscillator;
    logic pll;
    logic regulator;
    logic low_power_reg;
    logic core_domain;
  } clock_gates_type;
endpackage : lpm_pkg

/* clk_prescaler.sv */
// bus clock enable divider
`timescale 1ns/1ps
`default_nettype none
module clk_prescaler (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic [3:0] div_i,
  // enable pulse
  output logic tick_o
);
  logic [3:0] count_reg;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (!run_i) begin
      count_reg <= 4'h0;
      tick_o <= 1'b0;
    end else if (count_reg >= div_i) begin
      count_reg <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      count_reg <= count_reg + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : clk_prescaler
`default_nettype wire

/* lpm_core_model.sv */
// core and wake source model facing the power supervisor
`timescale 1ns/1ps
`default_nettype none
module lpm_core_model (
  // clock
  input wire logic clk_i,
  // core requests
  output logic wfi_o,
  output logic wfe_o,
  output logic irq_o,
  output logic event_o,
  // wake and reset pins
  output logic [15:0] lines_o,
  output logic wake_pin_o,
  output logic rst_pin_n_o,
  output logic wdg_o
);
  // ----------------------------------------------------------------
  // idle levels of every source
  // ----------------------------------------------------------------
  task automatic idle();
    wfi_o <= 1'b0;
    wfe_o <= 1'b0;
    irq_o <= 1'b0;
    event_o <= 1'b0;
    lines_o <= 16'h0000;
    wake_pin_o <= 1'b0;
    rst_pin_n_o <= 1'b1;
    wdg_o <= 1'b0;
  endtask : idle

  initial begin
    idle();
  end

  // software has already written the mode bits
  task automatic halt(input logic use_wfe);
    @(posedge clk_i);
    wfi_o <= ~use_wfe;
    wfe_o <= use_wfe;
    @(posedge clk_i);
    wfi_o <= 1'b0;
    wfe_o <= 1'b0;
  endtask : halt

  // one source held for two cycles, then released to idle
  task automatic wake(input int src, input int ln);
    @(posedge clk_i);
    case (src)
      0: irq_o <= 1'b1;
      1: event_o <= 1'b1;
      2: lines_o[ln] <= 1'b1;
      3: wake_pin_o <= 1'b1;
      4: wdg_o <= 1'b1;
      default: rst_pin_n_o <= 1'b0;
    endcase
    repeat (2) @(posedge clk_i);
    idle();
  endtask : wake
endmodule : lpm_core_model
`default_nettype wire

/* low_power_mode_and_clock_supervisor_tb_top.sv */
// self-checking bench for the power mode and clock supervisor
`timescale 1ns/1ps
`default_nettype none
`include "lpm_map.svh"
module low_power_mode_and_clock_supervisor_tb_top;
  import lpm_pkg::*;
  typedef struct {logic [31:0] d; logic [31:0] m; logic e;} note_type;
  logic clk_i, rst_i, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic wait_for_interrupt_instr, wait_for_event_instr, irq_any, wev, wpin, rpin_n, wdg, saw_rst;
  logic [15:0] lines;
  logic thr_rst, vmon, clk_ok, boot_pin, boot_bit;
  logic sys_clk_ext_o, chip_reset_o, irq_o;
  logic [2:0] bus_clk_en_o;
  logic [1:0] boot_region_o;
  logic [11:0] div;
  clock_gates_type gates_o;
  note_type notes[$];
  note_type nt;
  int n_fail = 0;
  int tests_run = 0;
  int cyc = 0;
  int seed, n;
  logic [5:0] ctl [6] = '{6'h00, 6'h03, 6'h04, 6'h05, 6'h07, 6'h06};
  power_state_type st [6] = '{SLEEP, SLEEP, STOP, STOP, DSTOP, STANDBY};

  low_power_mode_and_clock_supervisor low_power_mode_and_clock_supervisor_inst (
    .clk_i(clk_i), .rst_i(rst_i), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .wait_for_interrupt_instr_i(wait_for_interrupt_instr), .wait_for_event_instr_i(wait_for_event_instr),
    .irq_any_i(irq_any), .wake_event_i(wev),
    .external_interrupt_lines_i(lines), .wake_pin_i(wpin),
    .external_reset_pin_n_i(rpin_n), .independent_watchdog_reset_i(wdg),
    .supply_threshold_reset_i(thr_rst), .supply_voltage_monitor_i(vmon),
    .ext_clock_valid_i(clk_ok), .boot_select_pin_i(boot_pin),
    .boot_option_bit_i(boot_bit), .gates_o(gates_o),
    .sys_clk_ext_o(sys_clk_ext_o), .bus_clk_en_o(bus_clk_en_o),
    .chip_reset_o(chip_reset_o), .boot_region_o(boot_region_o),
    .irq_o(irq_o));

  lpm_core_model lpm_core_model_inst (
    .clk_i(clk_i), .wfi_o(wait_for_interrupt_instr), .wfe_o(wait_for_event_instr), .irq_o(irq_any),
    .event_o(wev), .lines_o(lines), .wake_pin_o(wpin),
    .rst_pin_n_o(rpin_n), .wdg_o(wdg));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------
  // compare, report and bus tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] m,
                     input logic e);
    notes.push_back('{w ? 32'h0 : d, w ? 32'h0 : m, e});
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do @(posedge clk_i); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] d,
                    input logic [31:0] m);
    apb(1'b0, a, d, m, 1'b0);
  endtask : rd

  // waits out the internal reset, then one spare edge
  task automatic wait_rel();
    int k;
    k = 0;
    while (chip_reset_o !== 1'b0 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    @(posedge clk_i);
    chk(chip_reset_o, 1'b0, "reset release");
  endtask : wait_rel

  task automatic arm();
    @(negedge clk_i);
    saw_rst = 1'b0;
  endtask : arm

  task automatic chk_gates(input power_state_type s);
    case (s)
      SLEEP: chk({gates_o.core, gates_o.periph, gates_o.adc}, 3'h3,
                 "sleep gates");
      STOP: chk({gates_o.periph, gates_o.internal_fast_oscillator,
                 gates_o.external_crystal_oscillator}, 3'h0,
                "stop gates");
      DSTOP: chk({gates_o.periph, gates_o.internal_fast_oscillator,
                  gates_o.external_crystal_oscillator, gates_o.pll}, 4'h0,
                 "deep stop gates");
      default: chk({gates_o.regulator, gates_o.internal_fast_oscillator,
                    gates_o.external_crystal_oscillator, gates_o.pll}, 4'h0,
                   "standby gates");
    endcase
  endtask : chk_gates

  // ----------------------------------------------------------------
  // monitors: bus answers against the notes, reset seen, timeout
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (psel && penable && pready === 1'b1) begin
      nt = notes.pop_front();
      chk(prdata & nt.m, nt.d, "apb data");
      chk({31'h0, pslverr}, {31'h0, nt.e}, "apb error");
    end
    if (chip_reset_o === 1'b1) saw_rst <= 1'b1;
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 52496;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    {thr_rst, vmon, boot_pin, boot_bit, saw_rst} = 5'h02;
    clk_ok = 1'b1;
    rst_i = 1'b1;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_rel();
    chk({gates_o.internal_fast_oscillator, sys_clk_ext_o}, 2'h2, "rst clk");
    chk({30'h0, boot_region_o}, {30'h0, `BOOT_FLASH}, "boot region");
    rd(`CTRL_OFF, 32'h0, 32'h3F);
    rd(`PRESC_OFF, 32'h0, 32'hFFF);
    rd(`STAT_OFF, 32'h0, 32'h7);
    rd(`MASK_OFF, 32'h0, 32'h7);
    apb(1'b0, 12'h014, 32'h0, 32'hFFFFFFFF, 1'b1);
    apb(1'b1, 12'h01C, 32'hFFFFFFFF, 32'h0, 1'b1);
    for (int i = 0; i < 6; i++) begin
      wr(`CTRL_OFF, {26'h0, ctl[i]});
      lpm_core_model_inst.halt(i[0]);
      @(negedge clk_i);
      chk_gates(st[i]);
      rd(`STATE_OFF, {29'h0, st[i]}, 32'h7);
      arm();
      if (st[i] == SLEEP) lpm_core_model_inst.wake(i, 0);
      else if (st[i] != STANDBY) lpm_core_model_inst.wake(2, $unsigned($random(seed)) % 16);
      else begin
        lpm_core_model_inst.wake(2, 3);
        rd(`STATE_OFF, 32'h6, 32'h7);
        lpm_core_model_inst.wake(3, 0);
      end
      wait_rel();
      rd(`STATE_OFF, 32'h0, 32'h7);
      if (st[i] == STANDBY) chk(saw_rst, 1'b1, "standby reset");
      rd(`CTRL_OFF, st[i] == STANDBY ? 32'h0 : ctl[i], 32'h3F);
      if (st[i] == STOP) rd(`STAT_OFF, 32'h4, 32'h4);
      wr(`STAT_OFF, 32'h7);
    end
    div = 12'($random(seed));
    wr(`PRESC_OFF, {20'h0, div});
    for (int b = 0; b < 3; b++) begin
      n = 0;
      do @(negedge clk_i); while (bus_clk_en_o[b] !== 1'b1 && ++n < 40);
      n = 0;
      do begin
        @(negedge clk_i);
        n++;
      end while (bus_clk_en_o[b] !== 1'b1 && n < 40);
      chk(n, div[b*4 +: 4] + 32'h1, "bus period");
    end
    wr(`MASK_OFF, 32'h7);
    wr(`CTRL_OFF, 32'h28);
    repeat (2) @(negedge clk_i);
    chk(sys_clk_ext_o, 1'b1, "ext select");
    @(posedge clk_i) clk_ok <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk({sys_clk_ext_o, gates_o.pll, gates_o.external_crystal_oscillator},
        3'h0, "fallback");
    chk(irq_o, 1'b1, "fail irq");
    @(posedge clk_i) clk_ok <= 1'b1;
    repeat (2) @(negedge clk_i);
    chk(sys_clk_ext_o, 1'b0, "blocked");
    rd(`STATE_OFF, 32'h10, 32'h10);
    wr(`STAT_OFF, 32'h1);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'b0, "irq cleared");
    wr(`CTRL_OFF, 32'h0);
    wr(`CTRL_OFF, 32'h20);
    @(posedge clk_i) clk_ok <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'b0, "no irq unmonitored");
    rd(`STAT_OFF, 32'h0, 32'h1);
    wr(`CTRL_OFF, 32'h0);
    @(posedge clk_i) vmon <= ~vmon;
    rd(`STAT_OFF, 32'h0, 32'h2);
    wr(`MASK_OFF, 32'h0);
    wr(`CTRL_OFF, 32'h10);
    @(posedge clk_i) vmon <= ~vmon;
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'b0, "masked irq");
    rd(`STAT_OFF, 32'h2, 32'h2);
    wr(`MASK_OFF, 32'h2);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'b1, "monitor irq");
    wr(`STAT_OFF, 32'h2);
    repeat (2) @(negedge clk_i);
    chk(irq_o, 1'b0, "monitor clear");
    wr(`CTRL_OFF, 32'h5);
    lpm_core_model_inst.halt(1'b0);
    arm();
    lpm_core_model_inst.wake(4, 0);
    wait_rel();
    chk(saw_rst, 1'b1, "watchdog wake");
    wr(`CTRL_OFF, 32'h6);
    lpm_core_model_inst.halt(1'b1);
    arm();
    lpm_core_model_inst.wake(5, 0);
    wait_rel();
    chk(saw_rst, 1'b1, "reset pin");
    @(posedge clk_i) thr_rst <= 1'b1;
    boot_pin <= 1'b1;
    repeat (5) @(negedge clk_i);
    chk(chip_reset_o, 1'b1, "supply low");
    @(posedge clk_i) thr_rst <= 1'b0;
    wait_rel();
    chk({chip_reset_o, sys_clk_ext_o}, 2'h0, "supply ok");
    chk({30'h0, boot_region_o}, {30'h0, `BOOT_SRAM}, "boot straps");
    chk(notes.size(), 32'h0, "unanswered");
    test_done();
  end
endmodule : low_power_mode_and_clock_supervisor_tb_top
`default_nettype wire
